// ==== common/frr_defs.vh ====
// constants for the functional reset routing block
`ifndef FRR_DEFS_VH
`define FRR_DEFS_VH

// ========================================
// sources
`define FRR_NSRC 9
`define FRR_SRC_EXTERNAL 0
`define FRR_SRC_FLASH 1
`define FRR_SRC_PLL_RANGE 2
`define FRR_SRC_OSC_LOW 3
`define FRR_SRC_PLL_FAIL 4
`define FRR_SRC_HALT_STOP 5
`define FRR_SRC_SOFTWARE 6
`define FRR_SRC_CPU 7
`define FRR_SRC_TEST_PORT 8

// ========================================
// register map
`define FRR_ADDR_ALT_SELECT 8'h00
`define FRR_ADDR_SHORT_SELECT 8'h04
`define FRR_ADDR_PENDING 8'h08
`define FRR_ALT_MASK 16'h019C
`define FRR_SHORT_MASK 16'h01FF
`define FRR_ALT_RESET 16'h0000
`define FRR_SHORT_RESET 16'h0000

// ========================================
// bus answers
`define FRR_RESP_OKAY 2'h0
`define FRR_RESP_SLVERR 2'h2

`endif

// ==== logic/frr_alt_queue.v ====
// pending alternate requests, presented one at a time
`timescale 1ns/1ps
`default_nettype none
module frr_alt_queue #(
  parameter N = 9,
  parameter SW = 4
) (
  input wire mclk,
  input wire rst,
  input wire [N-1:0] set,
  input wire clear_all,
  output wire req,
  input wire ack,
  output reg [SW-1:0] src,
  output reg [N-1:0] pend
);
  // ========================================
  // pending bits
  reg [N-1:0] next_pend;
  reg [SW-1:0] next_src;
  reg [N-1:0] taken;
  integer i;

  always @* begin
    taken = {N{1'b0}};
    if (req && ack) begin
      taken[src] = 1'b1;
    end
    // a new occurrence in the ack cycle stays pending
    next_pend = (pend & ~taken) | set;
    if (clear_all) begin
      next_pend = {N{1'b0}};
    end
    next_src = {SW{1'b0}};
    for (i = N - 1; i >= 0; i = i - 1) begin
      if (next_pend[i]) begin
        next_src = i[SW-1:0];
      end
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      pend <= {N{1'b0}};
      src <= {SW{1'b0}};
    end else begin
      pend <= next_pend;
      src <= next_src;
    end
  end

  assign req = |pend;
endmodule // frr_alt_queue
`default_nettype wire

// ==== logic/frr_routing.v ====
// functional reset routing: alternate requests and sequence-start selection
`timescale 1ns/1ps
`default_nettype none
`include "frr_defs.vh"
module frr_routing #(
  parameter AW = 8
) (
  input wire mclk,
  input wire rst,
  input wire [AW-1:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [AW-1:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire test_mode,
  input wire [15:0] functional_reset_disable_bits,
  input wire [`FRR_NSRC-1:0] func_event,
  input wire destructive_event,
  output wire safe_mode_req,
  output wire [3:0] safe_mode_src,
  input wire safe_mode_ack,
  output wire irq_req,
  output wire [3:0] irq_src,
  input wire irq_ack,
  output reg start_stage_one,
  output reg start_stage_three
);
  // ========================================
  // configuration registers
  reg [15:0] functional_alternate_request_select;
  reg [15:0] functional_short_sequence_select;

  // ========================================
  // local constants
  // the masks keep their full 16 bits here on purpose, so every cut below is visible
  localparam [15:0] ALT_MASK = `FRR_ALT_MASK;
  localparam [15:0] SHORT_MASK = `FRR_SHORT_MASK;
  localparam [15:0] SHORT_RESET = `FRR_SHORT_RESET;
  localparam [AW-1:0] ADDR_ALT = `FRR_ADDR_ALT_SELECT;
  localparam [AW-1:0] ADDR_SHORT = `FRR_ADDR_SHORT_SELECT;

  // ========================================
  // event routing
  wire [`FRR_NSRC-1:0] disabled;
  wire [`FRR_NSRC-1:0] alt_capable;
  wire [`FRR_NSRC-1:0] enabled_ev;
  wire [`FRR_NSRC-1:0] alt_ev;
  wire [`FRR_NSRC-1:0] safe_set;
  wire [`FRR_NSRC-1:0] irq_set;
  wire [`FRR_NSRC-1:0] short_sel;
  wire [`FRR_NSRC-1:0] safe_pend;
  wire [`FRR_NSRC-1:0] irq_pend;
  wire [`FRR_NSRC-1:0] long_ev;
  wire [`FRR_NSRC-1:0] short_ev;
  wire any_long;
  wire any_short;
  wire any_enabled;

  assign disabled = functional_reset_disable_bits[`FRR_NSRC-1:0];
  assign alt_capable = ALT_MASK[`FRR_NSRC-1:0];
  assign short_sel = functional_short_sequence_select[`FRR_NSRC-1:0];
  // a disabled source starts nothing; only sources with a select bit reroute
  assign enabled_ev = func_event & ~disabled;
  assign alt_ev = func_event & disabled & alt_capable;

  genvar g;
  generate
    for (g = 0; g < `FRR_NSRC; g = g + 1) begin : g_route
      // select 0: fallback-mode request, select 1: interrupt
      assign safe_set[g] = alt_ev[g] & ~functional_alternate_request_select[g];
      assign irq_set[g] = alt_ev[g] & functional_alternate_request_select[g];
      // short bit 0: full sequence from stage one, 1: skip to stage three
      assign long_ev[g] = enabled_ev[g] & ~short_sel[g];
      assign short_ev[g] = enabled_ev[g] & short_sel[g];
    end
  endgenerate

  // one short-sequence bit per source picks the entry stage
  assign any_long = |long_ev;
  assign any_short = |short_ev;
  assign any_enabled = |enabled_ev;

  // ========================================
  // sequence start
  // a long request in the same cycle as a short one wins: the full
  // sequence covers everything the short one would reset
  reg next_start_one;
  reg next_start_three;

  always @* begin
    next_start_one = 1'b0;
    next_start_three = 1'b0;
    // destructive events restart from stage zero elsewhere
    if (!destructive_event) begin
      if (any_long) begin
        next_start_one = 1'b1;
      end else if (any_short) begin
        next_start_three = 1'b1;
      end
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      start_stage_one <= 1'b0;
      start_stage_three <= 1'b0;
    end else begin
      start_stage_one <= next_start_one;
      start_stage_three <= next_start_three;
    end
  end

  // ========================================
  // alternate request queues
  frr_alt_queue #(
    .N(`FRR_NSRC),
    .SW(4)
  ) u_safe_q (
    .mclk(mclk),
    .rst(rst),
    .set(safe_set),
    .clear_all(destructive_event),
    .req(safe_mode_req),
    .ack(safe_mode_ack),
    .src(safe_mode_src),
    .pend(safe_pend)
  );

  frr_alt_queue #(
    .N(`FRR_NSRC),
    .SW(4)
  ) u_irq_q (
    .mclk(mclk),
    .rst(rst),
    .set(irq_set),
    .clear_all(destructive_event),
    .req(irq_req),
    .ack(irq_ack),
    .src(irq_src),
    .pend(irq_pend)
  );

  // ========================================
  // axi4-lite write channel
  reg aw_held;
  reg w_held;
  reg [AW-1:0] aw_addr;
  reg aw_priv;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire do_write;
  wire write_ok;
  wire [15:0] wmask;
  wire wr_alt;
  wire wr_short;

  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held & ~s_axi_bvalid;
  assign do_write = aw_held & w_held & ~s_axi_bvalid;
  // outside test mode, user privilege sees the registers read-only
  assign write_ok = aw_priv | test_mode;
  genvar b;
  generate
    for (b = 0; b < 2; b = b + 1) begin : g_lane
      assign wmask[8*b+7:8*b] = {8{w_strb[b]}};
    end
  endgenerate
  assign wr_alt = do_write & write_ok & (aw_addr == `FRR_ADDR_ALT_SELECT);
  assign wr_short = do_write & write_ok & (aw_addr == `FRR_ADDR_SHORT_SELECT);

  reg [1:0] next_bresp;
  reg addr_known;

  always @* begin
    addr_known = 1'b0;
    case (aw_addr)
      ADDR_ALT: addr_known = 1'b1;
      ADDR_SHORT: addr_known = 1'b1;
      default: addr_known = 1'b0;
    endcase
    next_bresp = `FRR_RESP_OKAY;
    if (!write_ok) begin
      next_bresp = `FRR_RESP_SLVERR;
    end else if (!addr_known) begin
      next_bresp = `FRR_RESP_SLVERR;
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= {AW{1'b0}};
      aw_priv <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `FRR_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        aw_priv <= s_axi_awprot[0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= next_bresp;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ========================================
  // register update
  reg [15:0] next_alt_select;
  reg [15:0] next_short_select;

  always @* begin
    next_alt_select = functional_alternate_request_select;
    next_short_select = functional_short_sequence_select;
    if (wr_alt) begin
      next_alt_select = ((functional_alternate_request_select & ~wmask) |
        (w_data[15:0] & wmask)) & ALT_MASK;
    end
    if (wr_short) begin
      next_short_select = ((functional_short_sequence_select & ~wmask) |
        (w_data[15:0] & wmask)) & SHORT_MASK;
    end
    // a reset event in the write cycle wins: the short-sequence select is cleared, the alternate select is not
    if (destructive_event || any_enabled) begin
      next_short_select = SHORT_RESET;
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      functional_alternate_request_select <= `FRR_ALT_RESET;
      functional_short_sequence_select <= `FRR_SHORT_RESET;
    end else begin
      functional_alternate_request_select <= next_alt_select;
      functional_short_sequence_select <= next_short_select;
    end
  end

  // ========================================
  // axi4-lite read channel
  reg [31:0] next_rdata;
  reg [1:0] next_rresp;

  assign s_axi_arready = ~s_axi_rvalid;

  always @* begin
    next_rdata = 32'h00000000;
    next_rresp = `FRR_RESP_OKAY;
    case (s_axi_araddr)
      `FRR_ADDR_ALT_SELECT: next_rdata = {16'h0000, functional_alternate_request_select};
      `FRR_ADDR_SHORT_SELECT: next_rdata = {16'h0000, functional_short_sequence_select};
      `FRR_ADDR_PENDING: next_rdata = {7'h00, irq_pend, 7'h00, safe_pend};
      default: next_rresp = `FRR_RESP_SLVERR;
    endcase
  end

  always @(posedge mclk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `FRR_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        // reads are open to every privilege level
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= next_rdata;
        s_axi_rresp <= next_rresp;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // frr_routing
`default_nettype wire

// ==== testbench/frr_routing_properties.sv ====
// port checker for the routing block
`timescale 1ns/1ps
`default_nettype none
`include "frr_defs.vh"
module frr_routing_chk (
  input wire mclk,
  input wire rst,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire test_mode,
  input wire [15:0] functional_reset_disable_bits,
  input wire [8:0] func_event,
  input wire destructive_event,
  input wire safe_mode_req,
  input wire safe_mode_ack,
  input wire irq_req,
  input wire irq_ack,
  input wire start_stage_one,
  input wire start_stage_three
);
  // ========================================
  // properties
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire [8:0] en_ev = func_event & ~functional_reset_disable_bits[8:0];
  wire [8:0] alt_ev = func_event & functional_reset_disable_bits[8:0] & 9'h19C;
  start_excl_a: assert property (!(start_stage_one && start_stage_three))
    else $error("both start pulses");
  start_cause_a: assert property (start_stage_one || start_stage_three |-> $past(|en_ev))
    else $error("start without enabled event");
  start_follow_a: assert property (|en_ev && !destructive_event |=> start_stage_one || start_stage_three)
    else $error("enabled event started nothing");
  alt_raise_a: assert property (|alt_ev && !destructive_event |=> safe_mode_req || irq_req)
    else $error("disabled event raised nothing");
  safe_hold_a: assert property (safe_mode_req && !safe_mode_ack && !destructive_event |=> safe_mode_req)
    else $error("fallback request dropped early");
  irq_hold_a: assert property (irq_req && !irq_ack && !destructive_event |=> irq_req)
    else $error("interrupt request dropped early");
  user_write_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    && !s_axi_awprot[0] && !test_mode |-> ##2 s_axi_bvalid && s_axi_bresp == `FRR_RESP_SLVERR)
    else $error("user write not refused");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  cover property (start_stage_three);
  cover property (safe_mode_req && safe_mode_ack);
  cover property (irq_req && irq_ack);
endmodule // frr_routing_chk
bind frr_routing frr_routing_chk u_chk (.*);
`default_nettype wire

// ==== testbench/frr_ctrl_model.sv ====
// receiver that acknowledges alternate requests
`timescale 1ns/1ps
`default_nettype none
module frr_ctrl_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic stall,
  input wire logic req,
  output logic ack
);
  // ========================================
  // handshake
  // ack drops after each take so a following source is never taken blind
  always @(posedge mclk) begin
    if (rst)
      ack <= 1'h0;
    else
      ack <= req && !ack && !stall;
  end
endmodule // frr_ctrl_model
`default_nettype wire

// ==== testbench/frr_routing_tb_top.sv ====
// testbench for the routing block
`timescale 1ns/1ps
`default_nettype none
module frr_routing_tb_top;
  logic mclk, rst, test_mode, destructive_event, stall, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, safe_mode_src, irq_src;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] functional_reset_disable_bits;
  logic [8:0] func_event;
  logic safe_mode_req, safe_mode_ack, irq_req, irq_ack, start_stage_one, start_stage_three;
  integer num_errors, checked, k, s;
  frr_routing dut (.*);
  frr_ctrl_model u_safe (.mclk(mclk), .rst(rst), .stall(stall), .req(safe_mode_req), .ack(safe_mode_ack));
  frr_ctrl_model u_irq (.mclk(mclk), .rst(rst), .stall(1'h0), .req(irq_req), .ack(irq_ack));
  // ========================================
  // helpers
  task chk(input [31:0] got, input [31:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task end_of_test;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task hang(input integer n);
    if (n > 40) begin
      num_errors = num_errors + 1;
      end_of_test;
    end
  endtask
  task wr(input [7:0] a, input [31:0] d, input [2:0] p, input [1:0] er);
    integer n;
    n = 0;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_awprot <= p;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge mclk);
      n = n + 1;
      hang(n);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    chk(s_axi_bresp, er);
  endtask
  task rd(input [7:0] a, input [31:0] ed, input [1:0] er);
    integer n;
    n = 0;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge mclk);
      n = n + 1;
      hang(n);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    chk(s_axi_rdata, ed);
    chk(s_axi_rresp, er);
  endtask
  // one-cycle event, then the start pulses one cycle later
  task fire(input [8:0] ev, input s1, input s3);
    @(posedge mclk);
    func_event <= ev;
    @(posedge mclk);
    func_event <= 9'h000;
    #1;
    chk(start_stage_one, s1);
    chk(start_stage_three, s3);
  endtask
  task alt(input integer k, input sel);
    integer n;
    logic a;
    a = (9'h19C >> k) & 1;
    n = 0;
    fire(9'h001 << k, 1'h0, 1'h0);
    chk({safe_mode_req, irq_req}, {a & !sel, a & sel});
    if (a) chk(sel ? irq_src : safe_mode_src, k);
    while (safe_mode_req || irq_req) begin
      @(posedge mclk);
      #1;
      n = n + 1;
      hang(n);
    end
    repeat (2) @(posedge mclk);
    chk({safe_mode_req, irq_req}, 0);
  endtask
  // ========================================
  // scenarios
  task reg_access;
    rd(8'h00, 0, 2'h0);
    rd(8'h04, 0, 2'h0);
    wr(8'h00, 32'hFFFFFFFF, 3'h1, 2'h0);
    rd(8'h00, 32'h19C, 2'h0);
    wr(8'h00, 0, 3'h0, 2'h2);
    rd(8'h00, 32'h19C, 2'h0);
    test_mode <= 1'h1;
    wr(8'h04, 32'hFFFF, 3'h0, 2'h0);
    test_mode <= 1'h0;
    rd(8'h04, 32'h1FF, 2'h0);
    rd(8'h0C, 0, 2'h2);
  endtask
  task alt_routing;
    functional_reset_disable_bits <= 16'h01FF;
    for (s = 0; s < 2; s = s + 1) begin
      wr(8'h00, s ? 32'h19C : 0, 3'h1, 2'h0);
      for (k = 0; k < 9; k = k + 1)
        alt(k, s[0]);
    end
  endtask
  // fallback receiver stalls with two sources pending
  task stall_hold;
    integer n;
    n = 0;
    wr(8'h00, 0, 3'h1, 2'h0);
    stall <= 1'h1;
    fire(9'h084, 1'h0, 1'h0);
    repeat (5) @(posedge mclk);
    chk({safe_mode_req, safe_mode_src}, 5'h12);
    stall <= 1'h0;
    while (safe_mode_src !== 4'h7) begin
      @(posedge mclk);
      #1;
      n = n + 1;
      hang(n);
    end
    chk(safe_mode_req, 1);
  endtask
  task seq_start;
    functional_reset_disable_bits <= 16'h0000;
    for (k = 0; k < 9; k = k + 1)
      for (s = 0; s < 2; s = s + 1) begin
        wr(8'h04, s << k, 3'h1, 2'h0);
        fire(9'h001 << k, !s, s[0]);
        rd(8'h04, 0, 2'h0);
      end
    wr(8'h04, 32'h4, 3'h1, 2'h0);
    fire(9'h005, 1'h1, 1'h0);
    wr(8'h04, 32'h1FF, 3'h1, 2'h0);
    @(posedge mclk);
    destructive_event <= 1'h1;
    @(posedge mclk);
    destructive_event <= 1'h0;
    rd(8'h04, 0, 2'h0);
    functional_reset_disable_bits <= 16'h0004;
    @(posedge mclk);
    func_event <= 9'h005;
    destructive_event <= 1'h1;
    @(posedge mclk);
    func_event <= 9'h000;
    destructive_event <= 1'h0;
    #1;
    chk({start_stage_one, start_stage_three, safe_mode_req, irq_req}, 0);
  endtask
  // ========================================
  // run
  initial begin
    mclk = 1'h0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    num_errors = 0;
    checked = 0;
    rst = 1'h1;
    {test_mode, destructive_event, stall, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 0;
    {s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata, func_event} = 0;
    functional_reset_disable_bits = 16'h0000;
    s_axi_wstrb = 4'hF;
    repeat (2) @(posedge mclk);
    rst <= 1'h0;
    reg_access;
    alt_routing;
    stall_hold;
    seq_start;
    end_of_test;
  end
endmodule // frr_routing_tb_top
`default_nettype wire
